// ### slusp_pkg.sv
// Shared constants and types for the serial link user stream port.
package slusp_pkg;
    localparam int          LANE_BYTES       = 8;
    localparam int          LANE_BITS        = 64;
    localparam int          GEAR_PERIOD      = 32;
    localparam logic [4:0]  GEAR_PAUSE_SLOT  = 5'h1F;
    localparam int          CC_PERIOD        = 10000;
    localparam logic [1:0]  CC_LEN           = 2'h3;
    localparam int          FIFO_DEPTH       = 8;
    localparam int          DEBOUNCE_CYCLES  = 4;
    localparam logic [3:0]  SEP_COUNT_EMPTY  = 4'h0;
    localparam logic [7:0]  KEEP_ALL         = 8'hFF;
    localparam logic [63:0] DATA_RST         = 64'h0000000000000000;
    localparam logic [7:0]  KEEP_RST         = 8'h00;

    typedef enum logic [1:0] {
        SLUSP_BLK_IDLE,
        SLUSP_BLK_DATA,
        SLUSP_BLK_SEP,
        SLUSP_BLK_CC
    } slusp_blk_t;

    typedef enum logic {
        SLUSP_TX_RUN,
        SLUSP_TX_EMPTY_SEPARATOR_BLOCK
    } slusp_tx_state_t;
endpackage

// ### slusp_fifo.sv
// Small synchronous valid/ready FIFO used in the transmit data path.
`timescale 1ns/100ps
module slusp_fifo #(
    parameter int W     = 73,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH):0]          count
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   count_r;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign count     = count_r;

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### slusp_port.sv
// Transmit and receive user stream port of a 64b/66b serial link layer.
//
// How it works
// - Drop tx ready one cycle per 32.
// - Clock comp sequence, three cycles every 10,000.
// - No data after idle or separator.
// - Full last block gets empty separator next.
// - Streaming mode carries words without delimiters.
// - Streaming idle gaps kept except during comp.
// - Transfer only when valid and ready.
// - Init clock output only for differential option.
// - Separator carries count; idle when no data.
`timescale 1ns/100ps
module slusp_port
    import slusp_pkg::*;
#(
    parameter int CC_PERIOD_CYC = CC_PERIOD,
    parameter int DEPTH         = FIFO_DEPTH,
    parameter bit DIFF_INIT_CLK = 1'b1
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 channel_up,
    input  wire logic                 streaming_mode,
    input  wire logic                 pma_init_pin,
    output logic                      pma_init_clean,
    input  wire logic                 init_clk_pin,
    output logic                      init_clk_out,
    input  wire logic [63:0]          s_axi_tx_tdata,
    input  wire logic [7:0]           s_axi_tx_tkeep,
    input  wire logic                 s_axi_tx_tlast,
    input  wire logic                 s_axi_tx_tvalid,
    output logic                      s_axi_tx_tready,
    output logic                      tx_block_valid,
    output slusp_blk_t                tx_block_type,
    output logic [63:0]               tx_block_data,
    output logic [3:0]                tx_sep_count,
    input  wire logic                 rx_block_valid,
    input  wire slusp_blk_t           rx_block_type,
    input  wire logic [63:0]          rx_block_data,
    input  wire logic [3:0]           rx_sep_count,
    output logic [63:0]               m_axi_rx_tdata,
    output logic [7:0]                m_axi_rx_tkeep,
    output logic                      m_axi_rx_tlast,
    output logic                      m_axi_rx_tvalid
);
    localparam int FW  = LANE_BITS + LANE_BYTES + 1;
    localparam int CW  = $clog2(CC_PERIOD_CYC);
    localparam int QW  = $clog2(DEPTH) + 1;

    // Pin synchronisers: the first stage feeds only the second.
    logic [2:0] pma_sync_r;
    logic [2:0] iclk_sync_r;
    logic [2:0] deb_cnt_r;
    logic       pma_init_r;
    logic       init_clk_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            pma_sync_r  <= 3'h0;
            iclk_sync_r <= 3'h0;
        end else if (ce) begin
            pma_sync_r  <= {pma_sync_r[1:0], pma_init_pin};
            iclk_sync_r <= {iclk_sync_r[1:0], init_clk_pin};
        end
    end

    // The init request must stay put for a few cycles before it is believed, so a glitchy
    // button or strap cannot bounce the link.
    wire pma_agree  = (pma_sync_r[2] == pma_sync_r[1]);
    wire pma_change = pma_agree && (pma_sync_r[2] != pma_init_r);
    wire deb_done   = (deb_cnt_r == 3'(DEBOUNCE_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            deb_cnt_r  <= 3'h0;
            pma_init_r <= 1'b0;
        end else if (ce) begin
            deb_cnt_r <= (pma_change && !deb_done) ? deb_cnt_r + 3'h1 : 3'h0;
            if (pma_change && deb_done) begin
                pma_init_r <= pma_sync_r[2];
            end
        end
    end

    // The forwarded init clock is a sampled copy; it is held low in the single-ended option.
    wire iclk_agree = (iclk_sync_r[2] == iclk_sync_r[1]);

    always_ff @(posedge clk) begin
        if (rst) begin
            init_clk_r <= 1'b0;
        end else if (ce && iclk_agree) begin
            init_clk_r <= DIFF_INIT_CLK ? iclk_sync_r[2] : 1'b0;
        end
    end

    assign pma_init_clean = pma_init_r;
    assign init_clk_out   = init_clk_r;

    // Gearbox pause and clock compensation timing.
    logic [4:0]    gear_r;
    logic [CW-1:0] cc_cnt_r;
    logic [1:0]    cc_left_r;

    wire          link_ok     = channel_up && !pma_init_r;
    wire [4:0]    gear_nxt    = gear_r + 5'h1;
    wire          pause_now   = (gear_r == GEAR_PAUSE_SLOT);
    wire          pause_nxt   = (gear_nxt == GEAR_PAUSE_SLOT);
    wire          cc_start    = (cc_cnt_r == CW'(CC_PERIOD_CYC - 1));
    wire [CW-1:0] cc_cnt_nxt  = cc_start ? '0 : cc_cnt_r + 1'b1;
    wire [1:0]    cc_left_nxt = cc_start ? CC_LEN : (cc_left_r != 2'h0) ? cc_left_r - 2'h1 : 2'h0;
    wire          cc_now      = (cc_left_r != 2'h0);
    wire          cc_nxt      = (cc_left_nxt != 2'h0);

    always_ff @(posedge clk) begin
        if (rst) begin
            gear_r    <= 5'h0;
            cc_cnt_r  <= '0;
            cc_left_r <= 2'h0;
        end else if (ce) begin
            gear_r    <= gear_nxt;
            cc_cnt_r  <= cc_cnt_nxt;
            cc_left_r <= cc_left_nxt;
        end
    end

    // Transmit FIFO; ready is only offered while a full cycle's worth of room remains.
    logic          tready_r;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic [FW-1:0] fifo_out_data;
    logic [QW-1:0] fifo_count;
    logic          fifo_pop;

    wire fifo_push = s_axi_tx_tvalid && tready_r && fifo_in_ready;
    wire room      = (fifo_count < QW'(DEPTH - 1));
    wire tready_nxt = link_ok && room && !pause_nxt && !cc_nxt;

    always_ff @(posedge clk) begin
        if (rst) begin
            tready_r <= 1'b0;
        end else if (ce) begin
            tready_r <= tready_nxt;
        end
    end

    assign s_axi_tx_tready = tready_r;

    slusp_fifo #(
        .W     (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   ({s_axi_tx_tlast, s_axi_tx_tkeep, s_axi_tx_tdata}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data),
        .count     (fifo_count)
    );

    // Lane scheduler: one block per slot, pause and compensation slots carry no user data.
    slusp_tx_state_t tx_st_r;
    logic            blk_valid_r;
    slusp_blk_t      blk_type_r;
    logic [63:0]     blk_data_r;
    logic [3:0]      blk_cnt_r;

    wire        w_last   = fifo_out_data[FW-1];
    wire [7:0]  w_keep   = fifo_out_data[FW-2 -: LANE_BYTES];
    wire [63:0] w_data   = fifo_out_data[LANE_BITS-1:0];
    wire        slot_ok  = !pause_now && !cc_now;
    wire        need_empty_separator_block = (tx_st_r == SLUSP_TX_EMPTY_SEPARATOR_BLOCK);
    wire        framed_end = !streaming_mode && w_last;
    wire        partial  = framed_end && (w_keep != KEEP_ALL);
    wire [3:0]  keep_cnt = 4'(w_keep[0]) + 4'(w_keep[1]) + 4'(w_keep[2]) + 4'(w_keep[3])
                         + 4'(w_keep[4]) + 4'(w_keep[5]) + 4'(w_keep[6]) + 4'(w_keep[7]);

    assign fifo_pop = slot_ok && !need_empty_separator_block && fifo_out_valid && link_ok;

    slusp_blk_t      type_nxt;
    slusp_tx_state_t st_nxt;

    always_comb begin
        type_nxt = SLUSP_BLK_IDLE;
        st_nxt   = tx_st_r;
        case (tx_st_r)
            SLUSP_TX_RUN: begin
                if (fifo_pop) begin
                    type_nxt = partial ? SLUSP_BLK_SEP : SLUSP_BLK_DATA;
                    if (framed_end && !partial) begin
                        st_nxt = SLUSP_TX_EMPTY_SEPARATOR_BLOCK;
                    end
                end
            end
            SLUSP_TX_EMPTY_SEPARATOR_BLOCK: begin
                type_nxt = SLUSP_BLK_SEP;
                if (slot_ok) begin
                    st_nxt = SLUSP_TX_RUN;
                end
            end
            default: begin
                st_nxt = SLUSP_TX_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st_r     <= SLUSP_TX_RUN;
            blk_valid_r <= 1'b0;
            blk_type_r  <= SLUSP_BLK_IDLE;
            blk_data_r  <= DATA_RST;
            blk_cnt_r   <= SEP_COUNT_EMPTY;
        end else if (ce) begin
            tx_st_r     <= st_nxt;
            blk_valid_r <= !pause_now;
            if (cc_now) begin
                blk_type_r <= SLUSP_BLK_CC;
                blk_data_r <= DATA_RST;
                blk_cnt_r  <= SEP_COUNT_EMPTY;
            end else if (!pause_now) begin
                // With one lane per slot a separator or idle is never followed by data in it.
                blk_type_r <= type_nxt;
                blk_data_r <= fifo_pop ? w_data : DATA_RST;
                blk_cnt_r  <= (fifo_pop && partial) ? keep_cnt : SEP_COUNT_EMPTY;
            end
        end
    end

    assign tx_block_valid = blk_valid_r;
    assign tx_block_type  = blk_type_r;
    assign tx_block_data  = blk_data_r;
    assign tx_sep_count   = blk_cnt_r;

    // Receive path. No ready exists, so every word is offered for exactly one cycle.
    // In framing one data word is held back until the next data or separator block shows whether it ends a frame.
    logic        hold_v_r;
    logic [63:0] hold_d_r;
    logic        tail_v_r;
    logic [63:0] tail_d_r;
    logic [7:0]  tail_k_r;
    logic [63:0] rx_d_r;
    logic [7:0]  rx_k_r;
    logic        rx_l_r;
    logic        rx_v_r;

    wire       rx_data  = rx_block_valid && (rx_block_type == SLUSP_BLK_DATA);
    wire       rx_sep   = rx_block_valid && (rx_block_type == SLUSP_BLK_SEP) && !streaming_mode;
    wire       sep_full = rx_sep && (rx_sep_count != SEP_COUNT_EMPTY);
    wire [7:0] sep_keep = 8'((9'h001 << rx_sep_count) - 9'h001);

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_v_r <= 1'b0;
            hold_d_r <= DATA_RST;
            tail_v_r <= 1'b0;
            tail_d_r <= DATA_RST;
            tail_k_r <= KEEP_RST;
            rx_d_r   <= DATA_RST;
            rx_k_r   <= KEEP_RST;
            rx_l_r   <= 1'b0;
            rx_v_r   <= 1'b0;
        end else if (ce) begin
            rx_v_r   <= 1'b0;
            tail_v_r <= 1'b0;
            if (streaming_mode) begin
                hold_v_r <= 1'b0;
                rx_v_r   <= rx_data;
                rx_d_r   <= rx_block_data;
                rx_k_r   <= KEEP_ALL;
                rx_l_r   <= 1'b0;
            end else if (tail_v_r) begin
                rx_v_r <= 1'b1;
                rx_d_r <= tail_d_r;
                rx_k_r <= tail_k_r;
                rx_l_r <= 1'b1;
                if (rx_data) begin
                    hold_v_r <= 1'b1;
                    hold_d_r <= rx_block_data;
                end
            end else if (rx_data) begin
                hold_v_r <= 1'b1;
                hold_d_r <= rx_block_data;
                rx_v_r   <= hold_v_r;
                rx_d_r   <= hold_d_r;
                rx_k_r   <= KEEP_ALL;
                rx_l_r   <= 1'b0;
            end else if (rx_sep) begin
                hold_v_r <= 1'b0;
                if (hold_v_r) begin
                    rx_v_r   <= 1'b1;
                    rx_d_r   <= hold_d_r;
                    rx_k_r   <= KEEP_ALL;
                    rx_l_r   <= !sep_full;
                    tail_v_r <= sep_full;
                    tail_d_r <= rx_block_data;
                    tail_k_r <= sep_keep;
                end else if (sep_full) begin
                    rx_v_r <= 1'b1;
                    rx_d_r <= rx_block_data;
                    rx_k_r <= sep_keep;
                    rx_l_r <= 1'b1;
                end
            end
        end
    end

    assign m_axi_rx_tdata  = rx_d_r;
    assign m_axi_rx_tkeep  = rx_k_r;
    assign m_axi_rx_tlast  = rx_l_r;
    assign m_axi_rx_tvalid = rx_v_r;
endmodule

// ### slusp_port_monitor.sv
// Concurrent checks on the boundary of the user stream port.
`timescale 1ns/100ps
module slusp_port_monitor
    import slusp_pkg::*;
#(
    parameter int CC_PERIOD_CYC = CC_PERIOD
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        channel_up,
    input wire logic        streaming_mode,
    input wire logic        pma_init_pin,
    input wire logic        pma_init_clean,
    input wire logic        init_clk_pin,
    input wire logic        init_clk_out,
    input wire logic        s_axi_tx_tready,
    input wire logic        tx_block_valid,
    input wire slusp_blk_t  tx_block_type,
    input wire logic [63:0] tx_block_data,
    input wire logic        rx_block_valid,
    input wire slusp_blk_t  rx_block_type,
    input wire logic [63:0] rx_block_data,
    input wire logic [63:0] m_axi_rx_tdata,
    input wire logic [7:0]  m_axi_rx_tkeep,
    input wire logic        m_axi_rx_tlast,
    input wire logic        m_axi_rx_tvalid
);
    logic [5:0]  rdy_run_r;
    logic [5:0]  vld_run_r;
    logic [15:0] cc_gap_r;
    logic        cc_seen_r;
    wire         cc_now   = tx_block_type == SLUSP_BLK_CC;
    wire         ctl_blk  = tx_block_type != SLUSP_BLK_DATA && tx_block_type != SLUSP_BLK_SEP;
    wire         rx_sdata = streaming_mode && rx_block_valid && rx_block_type == SLUSP_BLK_DATA;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Run lengths are counted rather than unrolled, since a pause is due every 32 cycles.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdy_run_r <= 6'h00;
            vld_run_r <= 6'h00;
            cc_gap_r  <= 16'h0000;
            cc_seen_r <= 1'b0;
        end else begin
            rdy_run_r <= s_axi_tx_tready ? rdy_run_r + 6'h01 : 6'h00;
            vld_run_r <= tx_block_valid ? vld_run_r + 6'h01 : 6'h00;
            cc_gap_r  <= (cc_now && !$past(cc_now)) ? 16'h0000 : cc_gap_r + 16'h0001;
            cc_seen_r <= cc_seen_r || cc_now;
        end
    end

    ready_gap_a: assert property (rdy_run_r <= 6'h1F)
        else $error("tx ready held high past a gearbox pause");
    valid_gap_a: assert property (vld_run_r <= 6'h1F)
        else $error("tx block valid held high past a gearbox pause");
    cc_length_a: assert property ($rose(cc_now) |-> cc_now [*3] ##1 !cc_now)
        else $error("clock comp sequence not three cycles");
    cc_period_a: assert property ($rose(cc_now) && cc_seen_r |-> cc_gap_r == 16'(CC_PERIOD_CYC - 1))
        else $error("clock comp sequence spacing wrong");
    ctl_zero_a: assert property (ctl_blk |-> tx_block_data == DATA_RST)
        else $error("idle or comp block carries data");
    init_block_a: assert property (pma_init_clean [*2] |-> !s_axi_tx_tready)
        else $error("tx ready high while init active");
    link_block_a: assert property (!channel_up [*2] |-> !s_axi_tx_tready)
        else $error("tx ready high while link down");
    init_debounce_a: assert property ($rose(pma_init_clean) |-> $past(pma_init_pin, 4) && $past(pma_init_pin, 5))
        else $error("init level passed without debounce");
    init_clock_a: assert property ($rose(init_clk_out) |-> init_clk_pin)
        else $error("init clock output does not follow pin");
    rx_stream_a: assert property (rx_sdata |=> m_axi_rx_tvalid && m_axi_rx_tdata == $past(rx_block_data) && m_axi_rx_tkeep == KEEP_ALL && !m_axi_rx_tlast)
        else $error("streaming word not presented next cycle");
endmodule

// ### slusp_user_model.sv
// Behavioural user application on the transmit and receive streams.
`timescale 1ns/100ps
module slusp_user_model #(
    parameter int DLY = 1
) (
    input  wire logic        clk,
    input  wire logic        s_axi_tx_tready,
    output logic [63:0]      s_axi_tx_tdata,
    output logic [7:0]       s_axi_tx_tkeep,
    output logic             s_axi_tx_tlast,
    output logic             s_axi_tx_tvalid,
    input  wire logic [63:0] m_axi_rx_tdata,
    input  wire logic [7:0]  m_axi_rx_tkeep,
    input  wire logic        m_axi_rx_tlast,
    input  wire logic        m_axi_rx_tvalid
);
    logic [72:0] rx_q[$];

    initial begin
        s_axi_tx_tdata  = 64'h0000000000000000;
        s_axi_tx_tkeep  = 8'h00;
        s_axi_tx_tlast  = 1'b0;
        s_axi_tx_tvalid = 1'b0;
    end

    // Received words cannot wait, so each is taken in the cycle it shows.
    always @(posedge clk) begin
        if (m_axi_rx_tvalid === 1'b1) begin
            rx_q.push_back({m_axi_rx_tlast, m_axi_rx_tkeep, m_axi_rx_tdata});
        end
    end

    // The beat stands from just after an edge until an edge that sees ready high.
    task automatic send(input logic [63:0] d, input logic [7:0] k, input logic l);
        int n;
        n = 0;
        s_axi_tx_tdata  = d;
        s_axi_tx_tkeep  = k;
        s_axi_tx_tlast  = l;
        s_axi_tx_tvalid = 1'b1;
        while (s_axi_tx_tready !== 1'b1 && n < 200) begin
            @(posedge clk);
            #DLY;
            n++;
        end
        // A stall that never ends is a failure of the run, not of this beat alone.
        if (s_axi_tx_tready !== 1'b1) begin
            slusp_port_tb_top.err_count++;
            slusp_port_tb_top.conclude();
        end
        @(posedge clk);
        #DLY;
    endtask

    // Released lines show the inverse so stale data never looks valid.
    task automatic idle();
        s_axi_tx_tvalid = 1'b0;
        s_axi_tx_tdata  = ~s_axi_tx_tdata;
        s_axi_tx_tkeep  = ~s_axi_tx_tkeep;
        s_axi_tx_tlast  = ~s_axi_tx_tlast;
    endtask
endmodule

// ### slusp_port_tb_top.sv
// Self-checking bench for the user stream port.
`timescale 1ns/100ps
module slusp_port_tb_top
    import slusp_pkg::*;
;
    localparam int DLY = 1;
    typedef struct {
        slusp_blk_t  t;
        logic [3:0]  c;
        logic [63:0] d;
        int          cyc;
    } slusp_tb_blk_t;

    logic        clk, rst, ce, channel_up, streaming_mode, pma_init_pin, pma_init_clean;
    logic        init_clk_pin, init_clk_out, tx_tlast, tx_tvalid, tx_tready, tx_block_valid;
    logic        rx_block_valid, rx_tlast, rx_tvalid;
    logic [63:0] tx_tdata, tx_block_data, rx_block_data, rx_tdata;
    logic [7:0]  tx_tkeep, rx_tkeep;
    logic [3:0]  tx_sep_count, rx_sep_count;
    slusp_blk_t  tx_block_type, rx_block_type;
    slusp_tb_blk_t txq[$];
    int          cyc = 0;
    int          err_count = 0;
    int          tests_run = 0;

    slusp_port #(.CC_PERIOD_CYC(200)) i_dut (
        .clk(clk), .rst(rst), .ce(ce), .channel_up(channel_up),
        .streaming_mode(streaming_mode), .pma_init_pin(pma_init_pin),
        .pma_init_clean(pma_init_clean), .init_clk_pin(init_clk_pin),
        .init_clk_out(init_clk_out), .s_axi_tx_tdata(tx_tdata), .s_axi_tx_tkeep(tx_tkeep),
        .s_axi_tx_tlast(tx_tlast), .s_axi_tx_tvalid(tx_tvalid), .s_axi_tx_tready(tx_tready),
        .tx_block_valid(tx_block_valid), .tx_block_type(tx_block_type),
        .tx_block_data(tx_block_data), .tx_sep_count(tx_sep_count),
        .rx_block_valid(rx_block_valid), .rx_block_type(rx_block_type),
        .rx_block_data(rx_block_data), .rx_sep_count(rx_sep_count),
        .m_axi_rx_tdata(rx_tdata), .m_axi_rx_tkeep(rx_tkeep), .m_axi_rx_tlast(rx_tlast),
        .m_axi_rx_tvalid(rx_tvalid)
    );

    slusp_user_model #(.DLY(DLY)) i_user (
        .clk(clk), .s_axi_tx_tready(tx_tready), .s_axi_tx_tdata(tx_tdata),
        .s_axi_tx_tkeep(tx_tkeep), .s_axi_tx_tlast(tx_tlast), .s_axi_tx_tvalid(tx_tvalid),
        .m_axi_rx_tdata(rx_tdata), .m_axi_rx_tkeep(rx_tkeep), .m_axi_rx_tlast(rx_tlast),
        .m_axi_rx_tvalid(rx_tvalid)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tx_block_valid && (tx_block_type == SLUSP_BLK_DATA || tx_block_type == SLUSP_BLK_SEP))
            txq.push_back('{tx_block_type, tx_sep_count, tx_block_data, cyc});
    end

    // A slow init clock, sampled by the port like any other pin.
    initial begin
        init_clk_pin = 1'b0;
        forever begin
            repeat (10) @(posedge clk);
            #DLY;
            init_clk_pin = ~init_clk_pin;
        end
    end

    task automatic conclude();
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [72:0] seen, input logic [72:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk);
        #DLY;
    endtask

    task automatic wait_n(input int n);
        for (int i = 0; i < 300 && txq.size() < n; i++) cyc_wait(1);
        if (txq.size() < n) begin
            err_count++;
            conclude();
        end
    endtask

    task automatic rx_blk(input slusp_blk_t t, input logic [63:0] d, input logic [3:0] c);
        rx_block_valid = 1'b1;
        rx_block_type  = t;
        rx_block_data  = d;
        rx_sep_count   = c;
        cyc_wait(1);
    endtask

    task automatic rx_end();
        rx_block_valid = 1'b0;
        rx_block_type  = SLUSP_BLK_IDLE;
        rx_block_data  = ~rx_block_data;
        cyc_wait(4);
    endtask

    task automatic t_frame(input logic [7:0] k);
        int n;
        n = (k === KEEP_ALL) ? 4 : 3;
        txq.delete();
        for (int i = 0; i < 3; i++) i_user.send(64'hA5A5000000000010 + 64'(i), (i == 2) ? k : KEEP_ALL, i == 2);
        i_user.idle();
        wait_n(n);
        cyc_wait(8);
        check("frame blocks", txq.size(), n);
        for (int i = 0; i < n - 1; i++) check("frame word", txq[i].d, 64'hA5A5000000000010 + 64'(i));
        check("sep type", txq[n-1].t, SLUSP_BLK_SEP);
        check("sep count", txq[n-1].c, (n == 4) ? SEP_COUNT_EMPTY : 4'($countones(k)));
        check("sep data", txq[n-1].d[23:0], (n == 4) ? 24'h000000 : 24'h000012);
    endtask

    task automatic t_stream();
        streaming_mode = 1'b1;
        txq.delete();
        i_user.send(64'h1111000000000001, KEEP_ALL, 1'b0);
        i_user.send(64'h1111000000000002, KEEP_ALL, 1'b1);
        i_user.idle();
        cyc_wait(4);
        i_user.send(64'h1111000000000003, KEEP_ALL, 1'b0);
        i_user.idle();
        wait_n(3);
        cyc_wait(8);
        check("stream blocks", txq.size(), 3);
        check("stream last", txq[2].d, 64'h1111000000000003);
        check("stream gap", txq[2].cyc - txq[1].cyc >= 5, 1'b1);
        streaming_mode = 1'b0;
    endtask

    task automatic t_rx();
        i_user.rx_q.delete();
        streaming_mode = 1'b1;
        rx_blk(SLUSP_BLK_DATA, 64'hC0C0000000000001, 4'h0);
        rx_blk(SLUSP_BLK_SEP, 64'h0000000000000077, 4'h1);
        rx_blk(SLUSP_BLK_DATA, 64'hC0C0000000000002, 4'h0);
        rx_end();
        check("rx stream words", i_user.rx_q.size(), 2);
        check("rx stream data", i_user.rx_q[1], {1'b0, KEEP_ALL, 64'hC0C0000000000002});
        streaming_mode = 1'b0;
        rx_blk(SLUSP_BLK_DATA, 64'hD0D0000000000001, 4'h0);
        rx_blk(SLUSP_BLK_SEP, DATA_RST, 4'h0);
        rx_blk(SLUSP_BLK_DATA, 64'hD0D0000000000002, 4'h0);
        rx_blk(SLUSP_BLK_CC, DATA_RST, 4'h0);
        rx_blk(SLUSP_BLK_SEP, 64'h0000000000ABCDEF, 4'h3);
        rx_end();
        check("rx frame words", i_user.rx_q.size(), 5);
        check("rx end empty", i_user.rx_q[2], {1'b1, KEEP_ALL, 64'hD0D0000000000001});
        check("rx held word", i_user.rx_q[3], {1'b0, KEEP_ALL, 64'hD0D0000000000002});
        check("rx tail", i_user.rx_q[4], {1'b1, 8'h07, 64'h0000000000ABCDEF});
    endtask

    task automatic t_init();
        pma_init_pin = 1'b1;
        cyc_wait(2);
        pma_init_pin = 1'b0;
        cyc_wait(10);
        check("init glitch", pma_init_clean, 1'b0);
        pma_init_pin = 1'b1;
        cyc_wait(12);
        check("init held", pma_init_clean, 1'b1);
        check("ready in init", tx_tready, 1'b0);
        pma_init_pin = 1'b0;
        channel_up = 1'b0;
        cyc_wait(12);
        check("init clear", pma_init_clean, 1'b0);
        check("ready link down", tx_tready, 1'b0);
        channel_up = 1'b1;
        cyc_wait(3);
    endtask

    task automatic t_rate();
        int lo = 0;
        int cc = 0;
        int rl = 0;
        for (int i = 0; i < 1600; i++) begin
            cyc_wait(1);
            lo += (tx_block_valid === 1'b0);
            rl += (tx_tready === 1'b0);
            cc += (tx_block_type === SLUSP_BLK_CC);
        end
        check("pause slots", lo, 50);
        check("comp cycles", cc, 24);
        // Pause and compensation slots never coincide with a 200-cycle period, so they add up.
        check("ready low", rl, 74);
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        channel_up = 1'b1;
        streaming_mode = 1'b0;
        pma_init_pin = 1'b0;
        rx_block_valid = 1'b0;
        rx_block_type = SLUSP_BLK_IDLE;
        rx_block_data = DATA_RST;
        rx_sep_count = 4'h0;
        cyc_wait(8);
        rst = 1'b0;
        cyc_wait(4);
        t_frame(KEEP_ALL);
        t_frame(8'h07);
        t_stream();
        t_rx();
        t_init();
        t_rate();
        conclude();
    end
endmodule

bind slusp_port slusp_port_monitor #(.CC_PERIOD_CYC(CC_PERIOD_CYC)) i_mon (
    .clk(clk), .rst(rst), .channel_up(channel_up), .streaming_mode(streaming_mode),
    .pma_init_pin(pma_init_pin), .pma_init_clean(pma_init_clean), .init_clk_pin(init_clk_pin),
    .init_clk_out(init_clk_out), .s_axi_tx_tready(s_axi_tx_tready),
    .tx_block_valid(tx_block_valid), .tx_block_type(tx_block_type),
    .tx_block_data(tx_block_data), .rx_block_valid(rx_block_valid),
    .rx_block_type(rx_block_type), .rx_block_data(rx_block_data),
    .m_axi_rx_tdata(m_axi_rx_tdata), .m_axi_rx_tkeep(m_axi_rx_tkeep),
    .m_axi_rx_tlast(m_axi_rx_tlast), .m_axi_rx_tvalid(m_axi_rx_tvalid)
);
